//--- common/path_seq_consts.svh
// Constants for the data path activation and sleep sequencer link.
// Assumes both ends include this file and share one clock.
`ifndef PATH_SEQ_CONSTS_SVH
`define PATH_SEQ_CONSTS_SVH

`define LANES_DEFAULT      8
`define LANES_PER_PATH_DEF 4
`define STEP_CYCLES_DEF    4
`define LK_ADDR_W          3
`define LK_DATA_W          8
`define DEV_TX_MASK        3'h0
`define DEV_TEARDOWN_MASK  3'h1
`define DEV_PATH_FLAGS     3'h2
`define DEV_MOD_FLAGS      3'h3
`define DEV_MOD_STATE      3'h4
`define DEV_TX_ENABLE      3'h5
`define MASK_RESET         8'hFF
`define HOST_CTRL          8'h00
`define HOST_STATUS        8'h04
`define HOST_FWD_BASE      8'h20
`define HOST_FWD_TOP       8'h34

`endif

//--- common/path_seq_pkg.sv
// Types shared by both ends of the sequencer link.
// Assumes path_seq_consts.svh is compiled alongside.
`default_nettype none
package path_seq_pkg;
    typedef enum logic [2:0] {
        path_inactive       = 3'h0,
        path_initializing   = 3'h1,
        path_ready          = 3'h2,
        path_tx_turning_on  = 3'h3,
        path_active         = 3'h4,
        path_tx_turning_off = 3'h5,
        path_tearing_down   = 3'h6
    } path_state_e;

    typedef enum logic [2:0] {
        mod_booting       = 3'h0,
        mod_operational   = 3'h1,
        mod_powering_down = 3'h2,
        mod_sleeping      = 3'h3
    } mod_state_e;

    typedef enum logic [1:0] {
        host_idle = 2'h0,
        host_link = 2'h1,
        host_resp = 2'h2
    } host_state_e;
endpackage : path_seq_pkg
`default_nettype wire

//--- common/path_seq_if.sv
// Management link between host controller and module sequencer.
// Assumes one shared clock; requests are one-cycle pulses.
`include "path_seq_consts.svh"
`default_nettype none
interface path_seq_if;
    logic                     hw_sleep_request_pin;
    logic                     lk_req;
    logic                     lk_we;
    logic [`LK_ADDR_W-1:0]    lk_addr;
    logic [`LK_DATA_W-1:0]    lk_wdata;
    logic                     lk_ack;
    logic [`LK_DATA_W-1:0]    lk_rdata;
    logic                     irq;

    modport device (
        input  hw_sleep_request_pin, lk_req, lk_we, lk_addr, lk_wdata,
        output lk_ack, lk_rdata, irq
    );
    modport host (
        output hw_sleep_request_pin, lk_req, lk_we, lk_addr, lk_wdata,
        input  lk_ack, lk_rdata, irq
    );
endinterface : path_seq_if
`default_nettype wire

//--- core/path_seq_device.sv
// Module-side data path and module power state sequencer.
// Assumes the host keeps link requests to one-cycle pulses.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`include "path_seq_consts.svh"
`default_nettype none
module path_seq_device
    import path_seq_pkg::*;
#(
    parameter int LANES          = `LANES_DEFAULT,
    parameter int LANES_PER_PATH = `LANES_PER_PATH_DEF,
    parameter int STEP_CYCLES    = `STEP_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // Link to host
    path_seq_if.device            link,
    // Module side
    output logic [LANES-1:0]      o_tx_enable,
    output logic [LANES/LANES_PER_PATH-1:0] o_path_resources,
    output logic                  o_low_power
);
    localparam int NP = LANES / LANES_PER_PATH;

    // Lanes must split evenly into paths and fit one link word
    if (LANES > `LK_DATA_W || LANES_PER_PATH < 1 || LANES % LANES_PER_PATH != 0) begin : g_bad_lanes
        $error("Lane layout not supported");
    end
    // Dwell counters are eight bits wide
    if (STEP_CYCLES < 1 || STEP_CYCLES > 255) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    logic [LANES-1:0]  tx_mask_reg;
    logic [LANES-1:0]  teardown_mask_reg;
    logic [NP-1:0]     path_flag_reg;
    logic [NP-1:0]     path_flag_next;
    logic              mod_flag_reg;
    logic              mod_flag_next;
    logic [NP-1:0]     path_set;
    logic              mod_set;
    logic [NP-1:0]     path_is_inactive;
    path_state_e       st_reg  [NP];
    path_state_e       st_next [NP];
    mod_state_e        mod_reg;
    mod_state_e        mod_next;
    logic [7:0]        mod_cnt_reg;
    logic              sleep_req;
    logic              rd_path_flags;
    logic              rd_mod_flags;
    logic [NP-1:0]     tx_path_reg;
    logic [NP-1:0]     res_reg;
    logic              ack_reg;
    logic [`LK_DATA_W-1:0] rdata_reg;
    logic              irq_reg;

    assign sleep_req     = link.hw_sleep_request_pin;
    assign rd_path_flags = link.lk_req && !link.lk_we && link.lk_addr == `DEV_PATH_FLAGS;
    assign rd_mod_flags  = link.lk_req && !link.lk_we && link.lk_addr == `DEV_MOD_FLAGS;

    // Per-path state machines
    for (genvar p = 0; p < NP; p++) begin : g_path
        logic       deact;
        logic       tear;
        logic [7:0] cnt_reg;

        // Pin request forces deactivation in every module state, as does any set tx mask bit of the path
        assign deact = sleep_req || (|tx_mask_reg[p*LANES_PER_PATH +: LANES_PER_PATH]);
        assign tear  = sleep_req || mod_reg != mod_operational
                    || (|teardown_mask_reg[p*LANES_PER_PATH +: LANES_PER_PATH]);

        always_comb begin
            st_next[p]  = st_reg[p];
            path_set[p] = 1'b0;
            unique case (st_reg[p])
                path_inactive: begin
                    if (!tear)
                        st_next[p] = path_initializing;
                end
                path_initializing: begin
                    if (cnt_reg == 8'h00) begin
                        st_next[p]  = path_ready;
                        path_set[p] = 1'b1;
                    end
                end
                path_ready: begin
                    if (tear)
                        st_next[p] = path_tearing_down;
                    else if (!deact)
                        st_next[p] = path_tx_turning_on;
                end
                path_tx_turning_on: begin
                    if (cnt_reg == 8'h00) begin
                        st_next[p]  = path_active;
                        path_set[p] = 1'b1;
                    end
                end
                path_active: begin
                    if (deact)
                        st_next[p] = path_tx_turning_off;
                end
                path_tx_turning_off: begin
                    if (cnt_reg == 8'h00)
                        st_next[p] = path_ready;
                end
                path_tearing_down: begin
                    if (cnt_reg == 8'h00) begin
                        st_next[p]  = path_inactive;
                        path_set[p] = 1'b1;
                    end
                end
                default: begin
                    st_next[p] = path_inactive;
                end
            endcase
        end

        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                st_reg[p] <= path_inactive;
            end else begin
                st_reg[p] <= st_next[p];
            end
        end

        // Fixed dwell in each transient state
        always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
                cnt_reg <= 8'h00;
            end else if (st_next[p] != st_reg[p]) begin
                cnt_reg <= 8'(STEP_CYCLES - 1);
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end

        assign path_is_inactive[p] = st_reg[p] == path_inactive;
    end

    // Module power state
    always_comb begin
        mod_next = mod_reg;
        mod_set  = 1'b0;
        unique case (mod_reg)
            mod_booting: begin
                // Pin level at bring-up picks the flow
                mod_next = sleep_req ? mod_sleeping : mod_operational;
            end
            mod_operational: begin
                if (sleep_req && &path_is_inactive)
                    mod_next = mod_powering_down;
            end
            mod_powering_down: begin
                if (mod_cnt_reg == 8'h00) begin
                    mod_next = mod_sleeping;
                    mod_set  = 1'b1;
                end
            end
            mod_sleeping: begin
                if (!sleep_req) begin
                    mod_next = mod_operational;
                    mod_set  = 1'b1;
                end
            end
            default: begin
                mod_next = mod_booting;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mod_reg <= mod_booting;
        end else begin
            mod_reg <= mod_next;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mod_cnt_reg <= 8'h00;
        end else if (mod_next != mod_reg) begin
            mod_cnt_reg <= 8'(STEP_CYCLES - 1);
        end else if (mod_cnt_reg != 8'h00) begin
            mod_cnt_reg <= mod_cnt_reg - 8'h01;
        end
    end

    // Outputs follow next state so they line up with the state flops
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tx_path_reg <= '0;
            res_reg     <= '0;
            o_low_power <= 1'b1;
        end else begin
            for (int p = 0; p < NP; p++) begin
                tx_path_reg[p] <= st_next[p] == path_tx_turning_on
                               || st_next[p] == path_active;
                res_reg[p]     <= st_next[p] != path_inactive
                               && st_next[p] != path_tearing_down;
            end
            o_low_power <= mod_next == mod_powering_down
                        || mod_next == mod_sleeping
                        || mod_next == mod_booting;
        end
    end

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign o_tx_enable[l] = tx_path_reg[l / LANES_PER_PATH];
    end
    assign o_path_resources = res_reg;

    // Host-writable masks; all lanes disabled after reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tx_mask_reg       <= LANES'(`MASK_RESET);
            teardown_mask_reg <= LANES'(`MASK_RESET);
        end else if (link.lk_req && link.lk_we) begin
            if (link.lk_addr == `DEV_TX_MASK)
                tx_mask_reg <= link.lk_wdata[LANES-1:0];
            if (link.lk_addr == `DEV_TEARDOWN_MASK)
                teardown_mask_reg <= link.lk_wdata[LANES-1:0];
        end
    end

    // Change flags: reading clears, a new event in the same cycle wins
    always_comb begin
        path_flag_next = path_flag_reg;
        if (rd_path_flags)
            path_flag_next = '0;
        path_flag_next = path_flag_next | path_set;
        mod_flag_next  = (mod_flag_reg && !rd_mod_flags) || mod_set;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            path_flag_reg <= '0;
            mod_flag_reg  <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            path_flag_reg <= path_flag_next;
            mod_flag_reg  <= mod_flag_next;
            irq_reg       <= (|path_flag_next) || mod_flag_next;
        end
    end

    // Link answers one cycle after each request
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= link.lk_req;
            if (link.lk_req && !link.lk_we) begin
                unique case (link.lk_addr)
                    `DEV_TX_MASK:       rdata_reg <= `LK_DATA_W'(tx_mask_reg);
                    `DEV_TEARDOWN_MASK: rdata_reg <= `LK_DATA_W'(teardown_mask_reg);
                    `DEV_PATH_FLAGS:    rdata_reg <= `LK_DATA_W'(path_flag_reg);
                    `DEV_MOD_FLAGS:     rdata_reg <= `LK_DATA_W'(mod_flag_reg);
                    `DEV_MOD_STATE:     rdata_reg <= `LK_DATA_W'(mod_reg);
                    `DEV_TX_ENABLE:     rdata_reg <= `LK_DATA_W'(o_tx_enable);
                    default:            rdata_reg <= '0;
                endcase
            end
        end
    end

    assign link.lk_ack   = ack_reg;
    assign link.lk_rdata = rdata_reg;
    assign link.irq      = irq_reg;
endmodule : path_seq_device
`default_nettype wire

//--- core/path_seq_host.sv
// Host controller end: Avalon-MM slave for software, master of the link.
// Assumes software does the read-modify-write of device masks.
`include "path_seq_consts.svh"
`default_nettype none
module path_seq_host
    import path_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Link to device
    path_seq_if.host         link
);
    host_state_e           st_reg;
    logic                  sleep_reg;
    logic                  req_reg;
    logic                  we_reg;
    logic [`LK_ADDR_W-1:0] addr_reg;
    logic [`LK_DATA_W-1:0] wdata_reg;
    logic                  fwd_hit;
    logic                  busy;

    assign busy    = i_avs_read || i_avs_write;
    assign fwd_hit = i_avs_address >= `HOST_FWD_BASE && i_avs_address <= `HOST_FWD_TOP
                  && i_avs_address[1:0] == 2'b00;

    // Waitrequest stays high until the answer is ready
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg            <= host_idle;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
            req_reg           <= 1'b0;
            we_reg            <= 1'b0;
            addr_reg          <= '0;
            wdata_reg         <= '0;
        end else begin
            req_reg <= 1'b0;
            unique case (st_reg)
                host_idle: begin
                    if (busy && fwd_hit) begin
                        // Whole device register in one link read or write
                        req_reg   <= 1'b1;
                        we_reg    <= i_avs_write;
                        addr_reg  <= `LK_ADDR_W'((i_avs_address - `HOST_FWD_BASE) >> 2);
                        wdata_reg <= i_avs_writedata[`LK_DATA_W-1:0];
                        st_reg    <= host_link;
                    end else if (busy) begin
                        unique case (i_avs_address)
                            `HOST_CTRL:   o_avs_readdata <= {31'h0, sleep_reg};
                            `HOST_STATUS: o_avs_readdata <= {31'h0, link.irq};
                            default:      o_avs_readdata <= '0;
                        endcase
                        o_avs_waitrequest <= 1'b0;
                        st_reg            <= host_resp;
                    end
                end
                host_link: begin
                    if (link.lk_ack) begin
                        // Flag reads here clear the interrupt
                        o_avs_readdata    <= {24'h0, link.lk_rdata};
                        o_avs_waitrequest <= 1'b0;
                        st_reg            <= host_resp;
                    end
                end
                host_resp: begin
                    o_avs_waitrequest <= 1'b1;
                    st_reg            <= host_idle;
                end
                default: begin
                    st_reg <= host_idle;
                end
            endcase
        end
    end

    // Pin level held in a control bit; starts asserted (sleep)
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sleep_reg <= 1'b1;
        end else if (st_reg == host_idle && i_avs_write && i_avs_address == `HOST_CTRL) begin
            sleep_reg <= i_avs_writedata[0];
        end
    end

    assign link.hw_sleep_request_pin = sleep_reg;
    assign link.lk_req               = req_reg;
    assign link.lk_we                = we_reg;
    assign link.lk_addr              = addr_reg;
    assign link.lk_wdata             = wdata_reg;
endmodule : path_seq_host
`default_nettype wire

//--- bench/path_seq_props.sv
// Checker on the link between the host end and the device end.
// Assumes one clock, active-high reset and the device's default parameters.
`default_nettype none
module path_seq_props #(
    parameter int SETTLE = 60
) (
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       hw_sleep_request_pin,
    input wire logic       lk_req,
    input wire logic       lk_we,
    input wire logic [2:0] lk_addr,
    input wire logic       lk_ack,
    input wire logic [7:0] lk_rdata,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rd_taken;
    logic [7:0] asleep_cnt_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    assign rd_taken = lk_req & ~lk_we;

    // Saturates, so a long sleep never wraps into a false window
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            asleep_cnt_reg <= 8'h00;
        end else if (!hw_sleep_request_pin) begin
            asleep_cnt_reg <= 8'h00;
        end else if (asleep_cnt_reg < 8'(SETTLE)) begin
            asleep_cnt_reg <= asleep_cnt_reg + 8'h01;
        end
    end

    property p_ack_after_req;
        lk_req |=> lk_ack;
    endproperty
    a_ack_after_req: assert property (p_ack_after_req)
        else $error("link ack missing after request");
    property p_ack_cause;
        lk_ack |-> $past(lk_req);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("link ack without request");
    property p_rdata_change;
        !$stable(lk_rdata) |-> lk_ack;
    endproperty
    a_rdata_change: assert property (p_rdata_change)
        else $error("read data moved without ack");
    property p_irq_fall;
        $fell(irq) |-> $past(rd_taken) || $past(rd_taken, 2) || $past(rd_taken, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a read");
    property p_mod_flag_bits;
        rd_taken && lk_addr == 3'h3 |=> lk_rdata[7:1] == 7'h00;
    endproperty
    a_mod_flag_bits: assert property (p_mod_flag_bits)
        else $error("module flag word has stray bits");
    property p_state_code;
        rd_taken && lk_addr == 3'h4 |=> lk_rdata <= 8'h03;
    endproperty
    a_state_code: assert property (p_state_code)
        else $error("module state code out of range");
    property p_sleep_state;
        asleep_cnt_reg == 8'(SETTLE) && rd_taken && lk_addr == 3'h4 |=> lk_rdata == 8'h03;
    endproperty
    a_sleep_state: assert property (p_sleep_state)
        else $error("module not asleep under long sleep request");
    property p_sleep_tx_off;
        asleep_cnt_reg == 8'(SETTLE) && rd_taken && lk_addr == 3'h5 |=> lk_rdata == 8'h00;
    endproperty
    a_sleep_tx_off: assert property (p_sleep_tx_off)
        else $error("transmitters on under long sleep request");

    c_irq_rise: cover property ($rose(irq));
    c_sleep_read: cover property (asleep_cnt_reg == 8'(SETTLE) && rd_taken);
    c_flag_read: cover property (rd_taken && lk_addr == 3'h3 ##1 lk_rdata == 8'h01);
endmodule : path_seq_props
`default_nettype wire

//--- bench/data_path_activation_and_hw_powerdown_bench.sv
// Bench: software drives the host end over Avalon, device end is observed.
// Assumes the package, link interface and both design ends are compiled.
`include "path_seq_consts.svh"
`default_nettype none
module data_path_activation_and_hw_powerdown_bench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  tx_enable;
    logic [1:0]  path_res;
    logic        low_power;
    logic [31:0] rd;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    path_seq_if lnk ();
    path_seq_device #(.LANES(8), .LANES_PER_PATH(4), .STEP_CYCLES(4)) path_seq_device_inst (
        .i_clock(clock), .i_rst(rst), .link(lnk.device), .o_tx_enable(tx_enable),
        .o_path_resources(path_res), .o_low_power(low_power));
    path_seq_host path_seq_host_inst (
        .i_clock(clock), .i_rst(rst), .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .link(lnk.host));
    path_seq_props path_seq_props_inst (
        .i_clock(clock), .i_rst(rst), .hw_sleep_request_pin(lnk.hw_sleep_request_pin),
        .lk_req(lnk.lk_req), .lk_we(lnk.lk_we), .lk_addr(lnk.lk_addr), .lk_ack(lnk.lk_ack),
        .lk_rdata(lnk.lk_rdata), .irq(lnk.irq));

    always #5 clock = ~clock;

    task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        // Only the bench timeout ends a wait that never answers
        do begin @(posedge clock); n++; end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        `CHK("wait_cycles", (a >= `HOST_FWD_BASE) ? 4 : 2, n)
    endtask : av_xfer

    task automatic dev_rd(input logic [2:0] idx, input logic [7:0] e, input string nm);
        av_xfer(1'b0, `HOST_FWD_BASE + {3'h0, idx, 2'h0}, 32'h0);
        `CHK(nm, {24'h0, e}, rd)
    endtask : dev_rd

    task automatic dev_wr(input logic [2:0] idx, input logic [7:0] v);
        av_xfer(1'b1, `HOST_FWD_BASE + {3'h0, idx, 2'h0}, {24'h0, v});
    endtask : dev_wr

    // Bounded wait: 0 irq, 1 tx lanes, 2 low power
    task automatic wait_on(input int sel, input logic [7:0] e, input string nm);
        int n;
        logic [7:0] v;
        for (n = 0; n < 300; n++) begin
            v = (sel == 0) ? {7'h0, lnk.irq} : (sel == 1) ? tx_enable : {7'h0, low_power};
            if (v === e) break;
            @(posedge clock);
        end
        `CHK(nm, e, v)
    endtask : wait_on

    task automatic t_after_reset;
        av_xfer(1'b0, `HOST_CTRL, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        `CHK("sleep_pin", 1'b1, lnk.hw_sleep_request_pin)
        av_xfer(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        dev_rd(3'h4, 8'h03, "mod_state");
        `CHK("low_power", 1'b1, low_power)
        `CHK("tx", 8'h00, tx_enable)
        $display("test after_reset done");
    endtask : t_after_reset

    task automatic t_wake;
        av_xfer(1'b1, `HOST_CTRL, 32'h0);
        `CHK("sleep_pin", 1'b0, lnk.hw_sleep_request_pin)
        wait_on(0, 8'h01, "irq");
        dev_rd(3'h3, 8'h01, "mod_flag");
        dev_rd(3'h4, 8'h01, "mod_state");
        wait_on(0, 8'h00, "irq");
        `CHK("low_power", 1'b0, low_power)
        $display("test wake done");
    endtask : t_wake

    task automatic t_init_paths;
        dev_wr(3'h1, 8'h00);
        wait_on(0, 8'h01, "irq");
        dev_rd(3'h2, 8'h03, "path_flags");
        `CHK("resources", 2'b11, path_res)
        wait_on(0, 8'h00, "irq");
        $display("test init_paths done");
    endtask : t_init_paths

    task automatic t_activate;
        dev_rd(3'h0, 8'hFF, "tx_mask");
        // Only path 0 lanes cleared; path 1 keeps its bits
        dev_wr(3'h0, rd[7:0] & 8'hF0);
        wait_on(1, 8'h0F, "tx_lanes");
        wait_on(0, 8'h01, "irq");
        dev_rd(3'h2, 8'h01, "path_flags");
        wait_on(0, 8'h00, "irq");
        dev_rd(3'h5, 8'h0F, "tx_readback");
        $display("test activate done");
    endtask : t_activate

    task automatic t_hw_powerdown;
        int n;
        av_xfer(1'b1, `HOST_CTRL, 32'h1);
        `CHK("sleep_pin", 1'b1, lnk.hw_sleep_request_pin)
        wait_on(1, 8'h00, "tx_lanes");
        wait_on(2, 8'h01, "low_power");
        `CHK("resources", 2'b00, path_res)
        // Flags only clear on read, so both paths show together here
        dev_rd(3'h2, 8'h03, "path_flags");
        rd = 32'h0;
        for (n = 0; n < 20 && rd !== 32'h3; n++) begin
            av_xfer(1'b0, `HOST_FWD_BASE + 8'h10, 32'h0);
        end
        `CHK("mod_state", 32'h3, rd)
        dev_rd(3'h3, 8'h01, "mod_flag");
        wait_on(0, 8'h00, "irq");
        av_xfer(1'b0, `HOST_STATUS, 32'h0);
        `CHK("status", 32'h0, rd)
        repeat (64) @(posedge clock);
        dev_rd(3'h5, 8'h00, "tx_asleep");
        dev_rd(3'h4, 8'h03, "mod_asleep");
        $display("test hw_powerdown done");
    endtask : t_hw_powerdown

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_after_reset();
        t_wake();
        t_init_paths();
        t_activate();
        t_hw_powerdown();
        end_of_test();
    end
endmodule : data_path_activation_and_hw_powerdown_bench
`default_nettype wire
